/* verilog/sfp_pkg.sv */
// Shared constants and carrier types for the serial flash pin-function select block.
package sfp_pkg;
    localparam logic [7:0] ADDR_CFG1 = 8'h00;
    localparam logic [7:0] ADDR_CFG2 = 8'h04;
    localparam logic [7:0] ADDR_SR1 = 8'h08;
    localparam logic [7:0] ADDR_XFER = 8'h0C;
    localparam logic [7:0] ADDR_TX = 8'h10;
    localparam logic [7:0] ADDR_RX = 8'h14;
    localparam logic [7:0] ADDR_STAT = 8'h18;
    localparam int QUAD_BIT = 1;
    localparam int FOUR_WIRE_BIT = 3;
    localparam int RST_EN_BIT = 7;
    localparam int PROTECT_BIT = 7;
    localparam logic [7:0] CFG1_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] SR1_RST = 8'h00;
    localparam logic [7:0] XFER_RST = 8'h00;
    localparam logic [7:0] TX_RST = 8'h00;
    localparam logic [6:0] PINS_RST = 7'h3F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] W_ONE = 2'h0;
    localparam logic [1:0] W_TWO = 2'h1;
    localparam logic [1:0] W_FOUR = 2'h2;
    localparam int CLK_NS = 100;
    localparam int T_RP_NS = 200;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] RP_CNT = 4'(RP_CYC);

    typedef struct packed {
        logic lane2_data;
        logic lane2_guard;
        logic lane3_data;
        logic lane3_restart;
        logic write_blocked;
    } sfp_pinfn_s;

    typedef struct packed {
        logic [1:0] width;
        logic drive;
        logic [7:0] tx_byte;
    } sfp_linkcfg_s;
endpackage : sfp_pkg

/* verilog/sfp_sync.sv */
// Two-flop level synchroniser for a vector of independent bits.
`timescale 1ns/1ps
module sfp_sync #(
    parameter int W = 1
) (
    input wire logic clk, // Destination clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [W-1:0] rst_val, // Constant value taken during reset.
    input wire logic [W-1:0] d, // Asynchronous input.
    output logic [W-1:0] q // Synchronised output.
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= rst_val;
            q <= rst_val;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : sfp_sync

/* verilog/sfp_link.sv */
// Serial-clock side shifter: samples lanes on rising edge, drives them after falling edge.
`timescale 1ns/1ps
module sfp_link (
    input wire logic sck, // Serial clock from the host.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic select_n, // Select pin, high ends the frame.
    input wire sfp_pkg::sfp_linkcfg_s cfg, // Quasi-static settings from the register side.
    input wire logic [3:0] lane_in, // Lane levels.
    output logic [3:0] lane_out, // Lane drive values.
    output logic [7:0] rx_byte, // Last complete received byte.
    output logic rx_toggle // Flips once per received byte.
);
    logic frame_rst_n;
    logic [3:0] rx_cnt;
    logic [3:0] tx_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [7:0] next_rx;
    logic [7:0] tx_src;
    logic [3:0] step;

    // Settings only change between frames, so sampling them at the frame is safe.
    assign frame_rst_n = rst_n & ~select_n;
    assign step = (cfg.width == sfp_pkg::W_FOUR) ? 4'h4 :
                  (cfg.width == sfp_pkg::W_TWO) ? 4'h2 : 4'h1;
    assign next_rx = (cfg.width == sfp_pkg::W_FOUR) ? {rx_sh[3:0], lane_in} :
                     (cfg.width == sfp_pkg::W_TWO) ? {rx_sh[5:0], lane_in[1:0]} :
                     {rx_sh[6:0], lane_in[0]};
    assign tx_src = (tx_cnt == 4'h0) ? cfg.tx_byte : tx_sh;

    always_ff @(posedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rx_sh <= 8'h00;
            rx_cnt <= 4'h0;
        end else begin
            rx_sh <= next_rx;
            rx_cnt <= ((rx_cnt + step) == 4'h8) ? 4'h0 : rx_cnt + step;
        end
    end

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte <= 8'h00;
            rx_toggle <= 1'b0;
        end else if (!select_n && (rx_cnt + step) == 4'h8) begin
            rx_byte <= next_rx;
            rx_toggle <= ~rx_toggle;
        end
    end

    always_ff @(negedge sck or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_sh <= 8'h00;
            tx_cnt <= 4'h0;
            lane_out <= 4'h0;
        end else begin
            tx_cnt <= ((tx_cnt + step) == 4'h8) ? 4'h0 : tx_cnt + step;
            if (cfg.width == sfp_pkg::W_FOUR) begin
                lane_out <= tx_src[7:4];
                tx_sh <= {tx_src[3:0], 4'h0};
            end else if (cfg.width == sfp_pkg::W_TWO) begin
                lane_out <= {2'b00, tx_src[7:6]};
                tx_sh <= {tx_src[5:0], 2'b00};
            end else begin
                lane_out <= {2'b00, tx_src[7], 1'b0};
                tx_sh <= {tx_src[6:0], 1'b0};
            end
        end
    end
endmodule : sfp_link

/* verilog/sfp_top.sv */
// Pin-function select for a multi-lane serial flash interface, with AXI4-Lite registers.
`timescale 1ns/1ps
module sfp_top (
    input wire logic aclk, // Register clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [7:0] awaddr, // Write address.
    input wire logic awvalid, // Write address valid.
    output logic awready, // Write address ready.
    input wire logic [31:0] wdata, // Write data.
    input wire logic [3:0] wstrb, // Write byte strobes.
    input wire logic wvalid, // Write data valid.
    output logic wready, // Write data ready.
    output logic [1:0] bresp, // Write response.
    output logic bvalid, // Write response valid.
    input wire logic bready, // Write response ready.
    input wire logic [7:0] araddr, // Read address.
    input wire logic arvalid, // Read address valid.
    output logic arready, // Read address ready.
    output logic [31:0] rdata, // Read data.
    output logic [1:0] rresp, // Read response.
    output logic rvalid, // Read data valid.
    input wire logic rready, // Read data ready.
    input wire logic sck, // Serial clock from the host.
    input wire logic select_n, // Select pin, active low.
    input wire logic restart_n, // Dedicated restart pin, active low.
    input wire logic [3:0] lane_in, // Lane pin levels, lane0 to lane3.
    output logic [3:0] lane_out, // Lane drive values.
    output logic [3:0] lane_oe, // Lane output enables, high drives.
    output sfp_pkg::sfp_pinfn_s pinfn, // Current pin functions.
    output logic standby // Idle and ready for a command.
);
    logic [7:0] config_one_volatile;
    logic [7:0] config_two_volatile;
    logic [7:0] status_one_nonvolatile;
    logic [7:0] xfer;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte_a;
    logic [7:0] rx_byte_l;
    logic rx_toggle_l;
    logic rx_toggle_s;
    logic rx_toggle_d;
    logic [6:0] pins_s;
    logic sel_low;
    logic sel_high;
    logic restart_s;
    logic [3:0] lanes_s;
    logic quad;
    logic four_wire;
    logic arm_lane3;
    logic [3:0] rp_cnt;
    logic lane3_reset;
    logic dev_rst;
    logic link_rst_n;
    logic rp_done;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_mapped;
    logic wr_blocked;
    logic rd_mapped;
    logic [31:0] rd_word;
    logic [1:0] req_width;
    logic [1:0] eff_width;
    logic [3:0] width_mask;
    sfp_pkg::sfp_linkcfg_s link_cfg;

    // Pins and the link's byte toggle pass two flops before any register-clock logic reads them; the link takes select_n and lane_in directly.
    sfp_sync #(.W(7)) u_pin_sync (
        .clk(aclk),
        .rst_n(aresetn),
        .rst_val(sfp_pkg::PINS_RST),
        .d({rx_toggle_l, restart_n, select_n, lane_in}),
        .q(pins_s)
    );
    assign lanes_s = pins_s[3:0];
    assign sel_high = pins_s[4];
    assign sel_low = ~pins_s[4];
    assign restart_s = pins_s[5];
    assign rx_toggle_s = pins_s[6];

    // Pin functions are pure decode so any register change applies to the next command.
    assign quad = config_one_volatile[sfp_pkg::QUAD_BIT];
    assign four_wire = config_two_volatile[sfp_pkg::FOUR_WIRE_BIT];
    assign pinfn.lane2_data = quad | four_wire;
    assign pinfn.lane2_guard = ~pinfn.lane2_data
        & status_one_nonvolatile[sfp_pkg::PROTECT_BIT];
    // Select high hands lane three to an enabled restart even in quad mode, so a host can reset.
    assign pinfn.lane3_restart = config_two_volatile[sfp_pkg::RST_EN_BIT]
        & ~((quad | four_wire) & sel_low);
    assign pinfn.lane3_data = (quad | (four_wire & sel_low)) & ~pinfn.lane3_restart;
    assign pinfn.write_blocked = pinfn.lane2_guard & ~lanes_s[2];

    // Four-wire mode forces four lanes; four lanes without quad fall back to two.
    assign req_width = xfer[1:0];
    assign eff_width = four_wire ? sfp_pkg::W_FOUR :
        (req_width == sfp_pkg::W_FOUR && !quad) ? sfp_pkg::W_TWO :
        (req_width == sfp_pkg::W_FOUR) ? sfp_pkg::W_FOUR :
        (req_width == sfp_pkg::W_TWO) ? sfp_pkg::W_TWO : sfp_pkg::W_ONE;
    assign width_mask = (eff_width == sfp_pkg::W_FOUR) ? 4'hF :
        (eff_width == sfp_pkg::W_TWO) ? 4'h3 : 4'h2;
    assign lane_oe = {4{sel_low & xfer[2]}} & width_mask;
    assign link_cfg.width = eff_width;
    assign link_cfg.drive = xfer[2];
    assign link_cfg.tx_byte = tx_byte;

    sfp_link u_link (
        .sck(sck),
        .rst_n(link_rst_n),
        .select_n(select_n),
        .cfg(link_cfg),
        .lane_in(lane_in),
        .lane_out(lane_out),
        .rx_byte(rx_byte_l),
        .rx_toggle(rx_toggle_l)
    );

    // Lane three restart: select high and lane low for the minimum pulse time.
    assign arm_lane3 = pinfn.lane3_restart & sel_high & ~lanes_s[3];
    assign lane3_reset = arm_lane3 && rp_cnt == sfp_pkg::RP_CNT && !rp_done;
    assign dev_rst = ~aresetn | ~restart_s | lane3_reset;
    assign standby = sel_high & ~dev_rst;

    always_ff @(posedge aclk) begin
        if (!aresetn || !arm_lane3) begin
            rp_cnt <= 4'h0;
            rp_done <= 1'b0;
        end else if (rp_cnt != sfp_pkg::RP_CNT) begin
            rp_cnt <= rp_cnt + 4'h1;
        end else begin
            rp_done <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        link_rst_n <= ~dev_rst;
        rx_toggle_d <= aresetn ? rx_toggle_s : 1'b0;
        // The link byte is stable for at least one byte time after its toggle.
        rx_byte_a <= !aresetn ? 8'h00 :
            (rx_toggle_s != rx_toggle_d) ? rx_byte_l : rx_byte_a;
    end

    // Write channel: address and data are taken in either order, then answered.
    assign awready = ~aw_full & ~bvalid;
    assign wready = ~w_full & ~bvalid;
    assign do_write = aw_full & w_full & ~bvalid;
    assign wr_mapped = aw_addr == sfp_pkg::ADDR_CFG1 || aw_addr == sfp_pkg::ADDR_CFG2
        || aw_addr == sfp_pkg::ADDR_SR1 || aw_addr == sfp_pkg::ADDR_XFER
        || aw_addr == sfp_pkg::ADDR_TX;
    // A guarded status or configuration write is dropped quietly.
    assign wr_blocked = pinfn.write_blocked && (aw_addr == sfp_pkg::ADDR_CFG1
        || aw_addr == sfp_pkg::ADDR_CFG2 || aw_addr == sfp_pkg::ADDR_SR1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= sfp_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_full <= 1'b1;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_full <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_mapped ? sfp_pkg::RESP_OKAY : sfp_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (dev_rst) begin
            config_one_volatile <= sfp_pkg::CFG1_RST;
            config_two_volatile <= sfp_pkg::CFG2_RST;
            xfer <= sfp_pkg::XFER_RST;
            tx_byte <= sfp_pkg::TX_RST;
        end else if (do_write && w_strb[0] && !wr_blocked) begin
            if (aw_addr == sfp_pkg::ADDR_CFG1) begin
                config_one_volatile <= w_data[7:0];
            end else if (aw_addr == sfp_pkg::ADDR_CFG2) begin
                config_two_volatile <= w_data[7:0];
            end else if (aw_addr == sfp_pkg::ADDR_XFER) begin
                xfer <= {5'h00, w_data[2:0]};
            end else if (aw_addr == sfp_pkg::ADDR_TX) begin
                tx_byte <= w_data[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_one_nonvolatile <= sfp_pkg::SR1_RST;
        end else if (do_write && w_strb[0] && !wr_blocked && aw_addr == sfp_pkg::ADDR_SR1) begin
            status_one_nonvolatile <= w_data[7:0];
        end
    end

    // Read channel: one read at a time, answered one cycle after the address is taken.
    assign arready = ~rvalid;
    assign rd_mapped = araddr == sfp_pkg::ADDR_CFG1 || araddr == sfp_pkg::ADDR_CFG2
        || araddr == sfp_pkg::ADDR_SR1 || araddr == sfp_pkg::ADDR_XFER
        || araddr == sfp_pkg::ADDR_TX || araddr == sfp_pkg::ADDR_RX
        || araddr == sfp_pkg::ADDR_STAT;
    assign rd_word = (araddr == sfp_pkg::ADDR_CFG1) ? {24'h000000, config_one_volatile} :
        (araddr == sfp_pkg::ADDR_CFG2) ? {24'h000000, config_two_volatile} :
        (araddr == sfp_pkg::ADDR_SR1) ? {24'h000000, status_one_nonvolatile} :
        (araddr == sfp_pkg::ADDR_XFER) ? {24'h000000, xfer} :
        (araddr == sfp_pkg::ADDR_TX) ? {24'h000000, tx_byte} :
        (araddr == sfp_pkg::ADDR_RX) ? {24'h000000, rx_byte_a} :
        (araddr == sfp_pkg::ADDR_STAT) ? {23'h000000, eff_width, standby, sel_high, pinfn} :
        32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= sfp_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_mapped ? sfp_pkg::RESP_OKAY : sfp_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence seq_lane3_held;
        arm_lane3 ##1 arm_lane3;
    endsequence

    AST_DESELECT_RELEASES: assert property (sel_high |-> lane_oe == 4'h0)
        else $error("lanes driven while deselected");
    AST_GUARD_FUNCTION: assert property ((!quad && !four_wire
        && status_one_nonvolatile[sfp_pkg::PROTECT_BIT]) |-> pinfn.lane2_guard)
        else $error("lane two not guard");
    AST_LANE3_DATA: assert property (((quad || four_wire) && sel_low)
        |-> (pinfn.lane3_data && !pinfn.lane3_restart))
        else $error("lane three not data");
    AST_LANE3_RESTART: assert property ((config_two_volatile[sfp_pkg::RST_EN_BIT]
        && sel_high && !four_wire) |-> pinfn.lane3_restart)
        else $error("lane three not restart");
    AST_RESTART_PULSE: assert property ($rose(lane3_reset)
        |-> $past(arm_lane3, 1) && $past(arm_lane3, 2) && sel_high)
        else $error("restart without held low pulse");
    AST_RESTART_FIRES: assert property ((!arm_lane3 ##1 seq_lane3_held ##1 arm_lane3)
        |-> lane3_reset)
        else $error("held restart not recognised");
    AST_HW_RESET: assert property (!restart_s |=> config_two_volatile == sfp_pkg::CFG2_RST
        && xfer == sfp_pkg::XFER_RST)
        else $error("restart pin did not clear config");
    AST_FOUR_WIRE: assert property ((four_wire && sel_low && xfer[2])
        |-> lane_oe == 4'hF && link_cfg.width == sfp_pkg::W_FOUR)
        else $error("four-wire mode not on four lanes");
    AST_SINGLE_LANE: assert property ((!four_wire && req_width == sfp_pkg::W_ONE
        && sel_low && xfer[2]) |-> lane_oe == 4'h2)
        else $error("single mode not on lane one");
    AST_BLOCKED_WRITE: assert property ((do_write && wr_blocked)
        |=> $stable(config_one_volatile) && $stable(status_one_nonvolatile))
        else $error("guarded write changed a register");
    AST_QUAD_RESTART: assert property ((quad && sel_high
        && config_two_volatile[sfp_pkg::RST_EN_BIT]) |-> pinfn.lane3_restart && !pinfn.lane3_data)
        else $error("quad idle lane three not restart");
    AST_LANE2_DATA: assert property ((quad || four_wire)
        |-> pinfn.lane2_data && !pinfn.lane2_guard)
        else $error("lane two not data in quad");
    // A lane-three restart is a single-cycle pulse; a held lane three must not keep the block in reset.
    AST_RESTART_ONCE: assert property (lane3_reset
        |=> !lane3_reset)
        else $error("restart pulse longer than one cycle");
endmodule : sfp_top

/* verification/sfp_host_model.sv */
// Behavioural host controller driving the serial clock, select and lanes.
`timescale 1ns/1ps
module sfp_host_model (
    output logic sck, // Serial clock, idles high between frames.
    output logic select_n, // Select, active low.
    output logic [3:0] drv, // Lane drive values.
    output logic [3:0] en, // Lane drive enables, high drives.
    input wire logic [3:0] lvl // Resolved lane levels.
);
    initial begin
        sck = 1'b1;
        select_n = 1'b1;
        drv = 4'hF;
        en = 4'h0;
    end
    // Pins move off the register clock's edge, as an unrelated host would.
    task automatic set_lane(input int i, input logic v, input logic on);
        #7;
        drv[i] = v;
        en[i] = on;
    endtask : set_lane
    task automatic set_sel(input logic v);
        #7;
        select_n = v;
    endtask : set_sel
    // Mode 3 framing: a falling edge launches a group, the next rising edge samples it.
    task automatic frame(input int w, input logic hdrv, input logic [7:0] tx,
                         output logic [7:0] rx);
        logic [3:0] mask;
        mask = 4'((1 << w) - 1);
        rx = 8'h00;
        #13;
        select_n = 1'b0;
        #400;
        for (int g = 0; g < 8 / w; g++) begin
            sck = 1'b0;
            drv = 4'(tx >> (8 - w * (g + 1))) & mask;
            en = (w == 1 || hdrv) ? mask : 4'h0;
            #40;
            sck = 1'b1;
            rx = (w == 1) ? {rx[6:0], lvl[1]} : 8'((rx << w) | (lvl & mask));
            #40;
        end
        // Lane three is driven high with select so that no restart can be seen.
        drv = 4'hF;
        en = 4'h8;
        select_n = 1'b1;
        #400;
        en = 4'h0;
    endtask : frame
endmodule : sfp_host_model

/* verification/serial_flash_pin_function_select_tb.sv */
// Self-checking bench for the pin-function select block and its host model.
`timescale 1ns/1ps
module serial_flash_pin_function_select_tb;
    logic aclk = 1'b0;
    logic aresetn, restart_n, sck, select_n, standby;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, lane_out, lane_oe, h_drv, h_en, lvl;
    logic [3:0] last_lvl = 4'h0;
    logic [1:0] bresp, rresp;
    sfp_pkg::sfp_pinfn_s pinfn;
    int fails = 0;
    int cmp_count = 0;

    always #50 aclk = ~aclk;
    // Lanes 2 and 3 have pull-ups; floating lanes 0 and 1 toggle so stale data never passes.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (lane_oe[i]) lvl[i] = lane_out[i];
            else if (h_en[i]) lvl[i] = h_drv[i];
            else lvl[i] = (i >= 2) ? 1'b1 : ~last_lvl[i];
        end
    end
    always @(posedge aclk) last_lvl <= lvl;

    sfp_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sck(sck), .select_n(select_n), .restart_n(restart_n), .lane_in(lvl),
        .lane_out(lane_out), .lane_oe(lane_oe), .pinfn(pinfn), .standby(standby));
    sfp_host_model h (.sck(sck), .select_n(select_n), .drv(h_drv), .en(h_en), .lvl(lvl));

    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic waitc(input int n);
        repeat (n) @(posedge aclk);
    endtask : waitc
    // Ready is sampled at the falling edge; inputs only move at rising edges, so it holds.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = sfp_pkg::RESP_OKAY);
        logic ah, wh, bh;
        logic [1:0] r;
        int n;
        n = 0;
        bh = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bh) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
            if (n > 50) begin
                fails++;
                stop_test();
            end
        end
        bready <= 1'b0;
        chk(32'(r), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er = sfp_pkg::RESP_OKAY);
        logic ah, rh;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = 0;
        rh = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rh) begin
            @(negedge aclk);
            ah = arvalid && arready;
            rh = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            n++;
            if (n > 50) begin
                fails++;
                stop_test();
            end
        end
        rready <= 1'b0;
        chk(32'(r), 32'(er));
        if (er == sfp_pkg::RESP_OKAY) chk(d, ed);
    endtask : rd

    task automatic t_regs();
        rd(sfp_pkg::ADDR_CFG1, 32'(sfp_pkg::CFG1_RST));
        rd(sfp_pkg::ADDR_CFG2, 32'(sfp_pkg::CFG2_RST));
        rd(sfp_pkg::ADDR_SR1, 32'(sfp_pkg::SR1_RST));
        rd(sfp_pkg::ADDR_XFER, 32'(sfp_pkg::XFER_RST));
        rd(sfp_pkg::ADDR_TX, 32'(sfp_pkg::TX_RST));
        rd(sfp_pkg::ADDR_STAT, 32'h00000060);
        wr(sfp_pkg::ADDR_XFER, 32'(sfp_pkg::W_FOUR));
        rd(sfp_pkg::ADDR_STAT, 32'h000000E0);
        wr(sfp_pkg::ADDR_XFER, 32'h0);
        rd(8'h1C, 32'h0, sfp_pkg::RESP_SLVERR);
        wr(8'h1C, 32'h0, sfp_pkg::RESP_SLVERR);
        $display("Done: register reset values");
    endtask : t_regs
    task automatic t_pins();
        logic [3:0] rows [4] = '{4'h0, 4'hB, 4'h3, 4'h4};
        logic q, f, r, p, s, rs;
        logic [4:0] e;
        for (int k = 0; k < 4; k++) begin
            {q, f, r, p} = rows[k];
            wr(sfp_pkg::ADDR_SR1, 32'({p, 7'h00}));
            wr(sfp_pkg::ADDR_CFG1, 32'({q, 1'b0}));
            wr(sfp_pkg::ADDR_CFG2, 32'({r, 3'h0, f, 3'h0}));
            for (int j = 0; j < 2; j++) begin
                s = (j == 0);
                h.set_sel(s);
                waitc(4);
                rs = r & ~((q | f) & ~s);
                e = {q | f, ~(q | f) & p, (q | (f & ~s)) & ~rs, rs, 1'b0};
                chk(32'(pinfn), 32'(e));
            end
        end
        h.set_sel(1'b1);
        wr(sfp_pkg::ADDR_CFG2, 32'h0);
        wr(sfp_pkg::ADDR_CFG1, 32'h0);
        wr(sfp_pkg::ADDR_SR1, 32'h0);
        $display("Done: pin functions");
    endtask : t_pins
    task automatic t_guard();
        wr(sfp_pkg::ADDR_SR1, 32'h80);
        h.set_lane(2, 1'b0, 1'b1);
        waitc(4);
        chk(32'(pinfn.write_blocked), 32'h1);
        wr(sfp_pkg::ADDR_CFG1, 32'h02);
        rd(sfp_pkg::ADDR_CFG1, 32'h00);
        h.set_lane(2, 1'b1, 1'b1);
        waitc(4);
        wr(sfp_pkg::ADDR_CFG1, 32'h02);
        rd(sfp_pkg::ADDR_CFG1, 32'h02);
        h.set_lane(2, 1'b1, 1'b0);
        wr(sfp_pkg::ADDR_SR1, 32'h0);
        wr(sfp_pkg::ADDR_CFG1, 32'h0);
        $display("Done: write guard");
    endtask : t_guard
    task automatic t_link();
        logic [1:0] wc [4] = '{sfp_pkg::W_ONE, sfp_pkg::W_TWO, sfp_pkg::W_FOUR, sfp_pkg::W_FOUR};
        int wn [4] = '{1, 2, 4, 4};
        logic dv [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        logic [7:0] hb, db, hr;
        for (int k = 0; k < 4; k++) begin
            hb = 8'h96 ^ 8'(k);
            db = 8'h5A ^ 8'(k);
            wr(sfp_pkg::ADDR_CFG2, (wn[k] == 4) ? 32'h08 : 32'h00);
            wr(sfp_pkg::ADDR_TX, 32'(db));
            wr(sfp_pkg::ADDR_XFER, 32'({dv[k], wc[k]}));
            chk(32'(lane_oe), 32'h0);
            h.frame(wn[k], ~dv[k], hb, hr);
            waitc(6);
            if (dv[k]) chk(32'(hr), 32'(db));
            if (!dv[k] || wn[k] == 1) rd(sfp_pkg::ADDR_RX, 32'(hb));
            chk(32'(lane_oe), 32'h0);
        end
        wr(sfp_pkg::ADDR_XFER, 32'h0);
        wr(sfp_pkg::ADDR_CFG2, 32'h0);
        $display("Done: link transfers");
    endtask : t_link
    task automatic t_lane3();
        wr(sfp_pkg::ADDR_CFG2, 32'h80);
        wr(sfp_pkg::ADDR_TX, 32'h5A);
        h.set_lane(3, 1'b0, 1'b1);
        waitc(1);
        h.set_lane(3, 1'b1, 1'b1);
        waitc(6);
        rd(sfp_pkg::ADDR_CFG2, 32'h80);
        h.set_lane(3, 1'b0, 1'b1);
        waitc(8);
        h.set_lane(3, 1'b1, 1'b1);
        waitc(6);
        h.set_lane(3, 1'b1, 1'b0);
        rd(sfp_pkg::ADDR_CFG2, 32'h00);
        rd(sfp_pkg::ADDR_TX, 32'h00);
        chk(32'(standby), 32'h1);
        $display("Done: lane three restart");
    endtask : t_lane3
    task automatic t_restart();
        wr(sfp_pkg::ADDR_CFG1, 32'h02);
        wr(sfp_pkg::ADDR_SR1, 32'h80);
        restart_n <= 1'b0;
        waitc(5);
        chk(32'(standby), 32'h0);
        restart_n <= 1'b1;
        waitc(5);
        chk(32'(standby), 32'h1);
        rd(sfp_pkg::ADDR_CFG1, 32'h00);
        rd(sfp_pkg::ADDR_SR1, 32'h80);
        wr(sfp_pkg::ADDR_SR1, 32'h0);
        $display("Done: dedicated restart");
    endtask : t_restart

    initial begin
        aresetn = 1'b0;
        restart_n = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_pins();
        t_guard();
        t_link();
        t_lane3();
        t_restart();
        stop_test();
    end
endmodule : serial_flash_pin_function_select_tb
